// ==== pio_defines.svh ====
/*
 Constants of the port I/O block: register addresses, reset values,
 synchroniser depth. Assumes a byte-wide special function register bus.
*/
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH
`define PIO_ADR_PORT0_DATA 8'h80
`define PIO_ADR_PORT0_DRVMODE 8'hA4
`define PIO_ADR_PORT1_CMPSEL 8'hBF
`define PIO_ADR_PORT1_EXPLVL 8'hCF
`define PIO_ADR_PORT0_BYPASS 8'hD4
`define PIO_ADR_PORT0_ANASEL 8'hF1
`define PIO_RST_DATA 8'hFF
`define PIO_RST_DRVMODE 8'h00
`define PIO_RST_CMPSEL 8'h00
`define PIO_RST_EXPLVL 8'hFF
`define PIO_RST_BYPASS 8'h00
`define PIO_RST_ANASEL 8'hFF
`define PIO_SYNC_STAGES 2
`endif

// ==== pio_pkg.sv ====
/*
 Types shared by the port I/O block.
 Assumes eight pins per port and an 8-bit register address.
*/
package pio_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic bit_wr;
    logic rmw;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } pio_sfr_req_t;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] drv_mode;
    logic [7:0] cmp_sel;
    logic [7:0] exp_lvl;
    logic [7:0] bypass;
    logic [7:0] analog_sel;
  } pio_regs_t;

  typedef struct packed {
    pio_regs_t regs;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic mismatch;
  } pio_state_t;
endpackage

// ==== pio_sync.sv ====
/*
 Multi-stage pin synchroniser.
 Assumes pins may change at any time relative to the clock.
*/
`timescale 1ns/10ps
`default_nettype none
module pio_sync #(
  parameter int W = 16,
  parameter int STAGES = 2
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [STAGES-1:0][W-1:0] chain;
  } pio_sync_st_t;

  pio_sync_st_t st_q;
  pio_sync_st_t st_d;

  // First stage feeds only the next stage
  always_comb begin
    st_d = st_q;
    if (ce_in) begin
      st_d.chain = {st_q.chain[STAGES-2:0], d_in};
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      // Idle pins sit high, so a chain of zeros would fake a change
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign q_out = st_q.chain[STAGES-1];
endmodule
`default_nettype wire

// ==== pio_port_cfg.sv ====
/*
 Port0 I/O configuration and port-match logic for two 8-bit ports.
 Assumes the core issues one register request per cycle, with rmw set
 for read-modify-write reads, and that the crossbar decoder, drive
 strength registers and first-port compare registers live outside.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pio_defines.svh"
module pio_port_cfg #(
  parameter int SYNC_STAGES = `PIO_SYNC_STAGES
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire pio_pkg::pio_sfr_req_t sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_rvalid_out,
  input wire logic [7:0] port0_pins_in,
  input wire logic [7:0] port1_pins_in,
  input wire logic [7:0] port0_compare_select_in,
  input wire logic [7:0] port0_expected_level_in,
  input wire logic crossbar_global_enable_in,
  input wire logic weak_pullup_disable_in,
  input wire logic [7:0] xbar_pin_sel_in,
  input wire logic [7:0] xbar_pin_data_in,
  input wire logic [7:0] twi_pin_sel_in,
  input wire logic [7:0] drive_strength_bits_in,
  output logic [7:0] port0_pin_out,
  output logic [7:0] port0_pin_oe_out,
  output logic [7:0] crossbar_bypass_bits_out,
  output logic [7:0] pullup_en_out,
  output logic [7:0] digital_rx_en_out,
  output logic [7:0] high_drive_out,
  output logic port2_pin7_digital_only_out,
  output logic port_mismatch_out
);
  pio_pkg::pio_state_t st_q;
  pio_pkg::pio_state_t st_d;
  logic [15:0] pins_s;
  logic [7:0] pins0_s;
  logic [7:0] pins1_s;
  logic [7:0] diff0;
  logic [7:0] diff1;
  logic mism;

  pio_sync #(
    .W(16),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .d_in({port1_pins_in, port0_pins_in}),
    .q_out(pins_s)
  );

  assign pins0_s = pins_s[7:0];
  assign pins1_s = pins_s[15:8];

  // Compared every cycle on synchronised pins, crossbar ignored
  assign diff0 = (pins0_s ^ port0_expected_level_in) &
                 port0_compare_select_in;
  assign diff1 = (pins1_s ^ st_q.regs.exp_lvl) &
                 st_q.regs.cmp_sel;
  assign mism = (|diff0) | (|diff1);

  function automatic logic [7:0] bit_set(input logic [7:0] v,
                                         input logic [2:0] b,
                                         input logic val);
    logic [7:0] r;
    r = v;
    r[b] = val;
    return r;
  endfunction

  always_comb begin
    logic [7:0] lvl;
    logic [7:0] od;
    logic [7:0] rd;
    pio_pkg::pio_regs_t r;
    lvl = '0;
    od = '0;
    rd = '0;
    r = st_q.regs;
    st_d = st_q;
    if (ce_in) begin
      // Byte writes land on this edge, bit writes patch one bit
      if (sfr_req_in.wr || sfr_req_in.bit_wr) begin
        case (sfr_req_in.addr)
          `PIO_ADR_PORT0_DATA: begin
            // Bit writes work from the latch, never the pins
            r.latch = sfr_req_in.wr ? sfr_req_in.wdata :
              bit_set(st_q.regs.latch, sfr_req_in.bit_sel,
                      sfr_req_in.wdata[0]);
          end
          `PIO_ADR_PORT0_DRVMODE: begin
            r.drv_mode = sfr_req_in.wr ? sfr_req_in.wdata :
              bit_set(st_q.regs.drv_mode, sfr_req_in.bit_sel,
                      sfr_req_in.wdata[0]);
          end
          `PIO_ADR_PORT1_CMPSEL: begin
            r.cmp_sel = sfr_req_in.wr ? sfr_req_in.wdata :
              bit_set(st_q.regs.cmp_sel, sfr_req_in.bit_sel,
                      sfr_req_in.wdata[0]);
          end
          `PIO_ADR_PORT1_EXPLVL: begin
            r.exp_lvl = sfr_req_in.wr ? sfr_req_in.wdata :
              bit_set(st_q.regs.exp_lvl, sfr_req_in.bit_sel,
                      sfr_req_in.wdata[0]);
          end
          `PIO_ADR_PORT0_BYPASS: begin
            r.bypass = sfr_req_in.wr ? sfr_req_in.wdata :
              bit_set(st_q.regs.bypass, sfr_req_in.bit_sel,
                      sfr_req_in.wdata[0]);
          end
          `PIO_ADR_PORT0_ANASEL: begin
            r.analog_sel = sfr_req_in.wr ? sfr_req_in.wdata :
              bit_set(st_q.regs.analog_sel, sfr_req_in.bit_sel,
                      sfr_req_in.wdata[0]);
          end
          default: begin
            r = st_q.regs;
          end
        endcase
      end
      st_d.regs = r;
      // Reads see current registers, but port0 data reads without rmw see the pins; unmapped reads give zero
      case (sfr_req_in.addr)
        `PIO_ADR_PORT0_DATA: begin
          rd = sfr_req_in.rmw ? st_q.regs.latch : pins0_s;
        end
        `PIO_ADR_PORT0_DRVMODE: rd = st_q.regs.drv_mode;
        `PIO_ADR_PORT1_CMPSEL: rd = st_q.regs.cmp_sel;
        `PIO_ADR_PORT1_EXPLVL: rd = st_q.regs.exp_lvl;
        `PIO_ADR_PORT0_BYPASS: rd = st_q.regs.bypass;
        `PIO_ADR_PORT0_ANASEL: rd = st_q.regs.analog_sel;
        default: rd = 8'h00;
      endcase
      st_d.rvalid = sfr_req_in.rd;
      if (sfr_req_in.rd) begin
        st_d.rdata = rd;
      end
      // Peripheral owns a pin only where the crossbar routed one
      lvl = (xbar_pin_sel_in & xbar_pin_data_in) |
            (~xbar_pin_sel_in & st_q.regs.latch);
      // Two-wire bus pins override the driver mode
      od = ~st_q.regs.drv_mode | twi_pin_sel_in;
      // Analog mode leaves the driver alone, so no term here
      st_d.pin_out = lvl & ~od;
      st_d.pin_oe = crossbar_global_enable_in ?
                    (~od | ~lvl) : 8'h00;
      st_d.mismatch = mism;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q.regs.latch <= `PIO_RST_DATA;
      st_q.regs.drv_mode <= `PIO_RST_DRVMODE;
      st_q.regs.cmp_sel <= `PIO_RST_CMPSEL;
      st_q.regs.exp_lvl <= `PIO_RST_EXPLVL;
      st_q.regs.bypass <= `PIO_RST_BYPASS;
      st_q.regs.analog_sel <= `PIO_RST_ANASEL;
      st_q.rdata <= 8'h00;
      st_q.rvalid <= 1'b0;
      st_q.pin_out <= 8'h00;
      st_q.pin_oe <= 8'h00;
      st_q.mismatch <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata_out = st_q.rdata;
  assign sfr_rvalid_out = st_q.rvalid;
  assign port0_pin_out = st_q.pin_out;
  assign port0_pin_oe_out = st_q.pin_oe;
  assign crossbar_bypass_bits_out = st_q.regs.bypass;
  assign pullup_en_out = st_q.regs.analog_sel &
                         {8{~weak_pullup_disable_in}};
  assign digital_rx_en_out = st_q.regs.analog_sel;
  // External strength bits reset low; only driven pins use them
  assign high_drive_out = drive_strength_bits_in & st_q.pin_oe;
  // That pin has no analog path, so its mode is fixed
  assign port2_pin7_digital_only_out = 1'b1;
  // One level feeds both the interrupt and the wake-up logic
  assign port_mismatch_out = st_q.mismatch;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  // Mismatch follows its cause by one edge, both ways
  mism_set_a: assert property (ce_in && mism |=> st_q.mismatch)
    else $error("mismatch not raised");
  mism_clr_a: assert property (ce_in && !mism |=> !st_q.mismatch)
    else $error("mismatch raised without cause");
  exp_level_a: assert property (ce_in && st_q.regs.cmp_sel[0] &&
    (pins1_s[0] != st_q.regs.exp_lvl[0]) |=> port_mismatch_out)
    else $error("unexpected level missed");
  mask_off_a: assert property (ce_in && st_q.regs.cmp_sel == 8'h00 &&
    port0_compare_select_in == 8'h00 |=> !port_mismatch_out)
    else $error("masked pins raised mismatch");
  p0_mism_a: assert property (ce_in && port0_compare_select_in[7] &&
    pins0_s[7] != port0_expected_level_in[7] |=> port_mismatch_out)
    else $error("port0 mismatch missed");
  latch_wr_a: assert property (ce_in && sfr_req_in.wr &&
    sfr_req_in.addr == `PIO_ADR_PORT0_DATA |=>
    st_q.regs.latch == $past(sfr_req_in.wdata))
    else $error("latch not written");
  latch_hold_a: assert property (!(ce_in && (sfr_req_in.wr ||
    sfr_req_in.bit_wr)) |=> $stable(st_q.regs.latch))
    else $error("latch changed without write");
  other_wr_a: assert property (ce_in && sfr_req_in.wr &&
    sfr_req_in.addr != `PIO_ADR_PORT0_DATA |=> $stable(st_q.regs.latch))
    else $error("latch hit by other write");
  pin_read_a: assert property (ce_in && sfr_req_in.rd &&
    !sfr_req_in.rmw && sfr_req_in.addr == `PIO_ADR_PORT0_DATA |=>
    sfr_rvalid_out && sfr_rdata_out == $past(pins0_s))
    else $error("data read not from pins");
  rmw_read_a: assert property (ce_in && sfr_req_in.rd &&
    sfr_req_in.rmw && sfr_req_in.addr == `PIO_ADR_PORT0_DATA |=>
    sfr_rdata_out == $past(st_q.regs.latch))
    else $error("rmw read not from latch");
  bit_wr_a: assert property (ce_in && sfr_req_in.bit_wr &&
    !sfr_req_in.wr && sfr_req_in.addr == `PIO_ADR_PORT0_DRVMODE |=>
    st_q.regs.drv_mode[$past(sfr_req_in.bit_sel)] ==
    $past(sfr_req_in.wdata[0]))
    else $error("bit write lost");
  // Bit writes to the latch touch only the addressed bit
  bit_lat_a: assert property (ce_in && sfr_req_in.bit_wr &&
    !sfr_req_in.wr && sfr_req_in.addr == `PIO_ADR_PORT0_DATA |=>
    st_q.regs.latch[$past(sfr_req_in.bit_sel)] ==
    $past(sfr_req_in.wdata[0]) &&
    (st_q.regs.latch & ~(8'h01 << $past(sfr_req_in.bit_sel))) ==
    ($past(st_q.regs.latch) & ~(8'h01 << $past(sfr_req_in.bit_sel))))
    else $error("latch bit write spilled");
  // A byte write wins over a bit write in the same cycle
  byte_wr_a: assert property (ce_in && sfr_req_in.wr &&
    sfr_req_in.addr == `PIO_ADR_PORT1_CMPSEL |=>
    st_q.regs.cmp_sel == $past(sfr_req_in.wdata))
    else $error("byte write lost");
  rd_valid_a: assert property (ce_in |=>
    sfr_rvalid_out == $past(sfr_req_in.rd))
    else $error("read valid pulse wrong");
  unmapped_a: assert property (ce_in && sfr_req_in.rd &&
    sfr_req_in.addr == 8'h81 |=> sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  cfg_rb_a: assert property (ce_in && sfr_req_in.wr && !sfr_req_in.rd
    && sfr_req_in.addr == `PIO_ADR_PORT0_ANASEL ##1 ce_in &&
    sfr_req_in.rd && !sfr_req_in.wr &&
    sfr_req_in.addr == `PIO_ADR_PORT0_ANASEL |=>
    sfr_rdata_out == $past(sfr_req_in.wdata, 2))
    else $error("config readback wrong");
  // Open-drain releases a high, push-pull drives both levels
  od_rel_a: assert property (ce_in && !st_q.regs.drv_mode[1] &&
    !xbar_pin_sel_in[1] && st_q.regs.latch[1] |=> !port0_pin_oe_out[1])
    else $error("open-drain pin driven high");
  pp_drive_a: assert property (ce_in && crossbar_global_enable_in &&
    st_q.regs.drv_mode[2] && !twi_pin_sel_in[2] && !xbar_pin_sel_in[2]
    |=> port0_pin_oe_out[2] &&
    port0_pin_out[2] == $past(st_q.regs.latch[2]))
    else $error("push-pull pin not driven from latch");
  xbar_pin_a: assert property (ce_in && crossbar_global_enable_in &&
    xbar_pin_sel_in[0] && st_q.regs.drv_mode[0] && !twi_pin_sel_in[0]
    |=> port0_pin_oe_out[0] &&
    port0_pin_out[0] == $past(xbar_pin_data_in[0]))
    else $error("routed pin not driven by peripheral");
  // Analog mode leaves the driver on but drops pullup and receiver
  ana_drv_a: assert property (ce_in && crossbar_global_enable_in &&
    !st_q.regs.analog_sel[3] && st_q.regs.drv_mode[3] &&
    !twi_pin_sel_in[3] |=> port0_pin_oe_out[3])
    else $error("analog pin lost its driver");
  ana_rx_a: assert property (!st_q.regs.analog_sel[3] |->
    !pullup_en_out[3] && !digital_rx_en_out[3])
    else $error("analog pin kept pullup or receiver");
  wpd_a: assert property (weak_pullup_disable_in |->
    pullup_en_out == 8'h00)
    else $error("pullup left on");
  rx_dig_a: assert property (st_q.regs.analog_sel[3] |->
    digital_rx_en_out[3])
    else $error("digital pin lost its receiver");
  twi_od_a: assert property (ce_in && |twi_pin_sel_in |=>
    (port0_pin_oe_out & port0_pin_out & $past(twi_pin_sel_in)) == 8'h00)
    else $error("bus pin driven high");
  xbar_off_a: assert property (ce_in && !crossbar_global_enable_in
    |=> port0_pin_oe_out == 8'h00)
    else $error("pin driven with crossbar off");
  hd_low_a: assert property (!drive_strength_bits_in[0] |->
    !high_drive_out[0])
    else $error("high drive without strength bit");
  // Clock enable low freezes registers and synchroniser alike
  ce_hold_a: assert property (!ce_in |=>
    $stable(st_q) && $stable(pins_s))
    else $error("state moved with clock enable low");

  mism_rise_c: cover property (!port_mismatch_out ##1 port_mismatch_out);
  rmw_rd_c: cover property (ce_in && sfr_req_in.rd && sfr_req_in.rmw);
  bit_wr_c: cover property (ce_in && sfr_req_in.bit_wr);
  ce_off_c: cover property (!ce_in ##1 ce_in);
  twi_c: cover property (crossbar_global_enable_in && |twi_pin_sel_in);
endmodule
`default_nettype wire

// ==== pio_pad_model.sv ====
/*
 Model of the port0 pads and the port1 pin levels.
 Assumes a pullup on every port0 pad and a bench-set port1 level.
*/
`timescale 1ns/10ps
`default_nettype none
module pio_pad_model (
  input wire logic [7:0] pin_in,
  input wire logic [7:0] oe_in,
  input wire logic [7:0] p1_lvl_in,
  output logic [7:0] p0_pins_out,
  output logic [7:0] p1_pins_out
);
  // A released pad floats up through its pullup, never keeps old data
  assign p0_pins_out = (pin_in & oe_in) | ~oe_in;
  assign p1_pins_out = p1_lvl_in;
endmodule
`default_nettype wire

// ==== tb_port_io_config_and_match.sv ====
/*
 Self-checking bench for pio_port_cfg: registers, pads, port match.
 Assumes pio_pad_model on the pads and a 250 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pio_defines.svh"
module tb_port_io_config_and_match;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  pio_pkg::pio_sfr_req_t req = '0;
  logic [7:0] rdata, p0_out, p0_oe, byp, pu, rx, hd, p0_pins, p1_pins;
  logic rvalid, p27, mism;
  logic [7:0] p1_lvl = 8'hFF, cmp0 = 8'h00, exp0 = 8'hFF;
  logic [7:0] xsel = 8'h00, xdat = 8'h00, twi = 8'h00, drv = 8'h00;
  logic xbe = 1'b0;
  logic wpd = 1'b0;
  logic ce = 1'b1;
  int errors = 0;
  int check_count = 0;
  always #2 clk = ~clk;
  pio_port_cfg uut (
    .clk_in(clk), .rstn_in(rstn), .ce_in(ce), .sfr_req_in(req),
    .sfr_rdata_out(rdata), .sfr_rvalid_out(rvalid),
    .port0_pins_in(p0_pins), .port1_pins_in(p1_pins),
    .port0_compare_select_in(cmp0), .port0_expected_level_in(exp0),
    .crossbar_global_enable_in(xbe), .weak_pullup_disable_in(wpd),
    .xbar_pin_sel_in(xsel), .xbar_pin_data_in(xdat),
    .twi_pin_sel_in(twi), .drive_strength_bits_in(drv),
    .port0_pin_out(p0_out), .port0_pin_oe_out(p0_oe),
    .crossbar_bypass_bits_out(byp), .pullup_en_out(pu),
    .digital_rx_en_out(rx), .high_drive_out(hd),
    .port2_pin7_digital_only_out(p27), .port_mismatch_out(mism)
  );
  pio_pad_model pads (
    .pin_in(p0_out), .oe_in(p0_oe), .p1_lvl_in(p1_lvl),
    .p0_pins_out(p0_pins), .p1_pins_out(p1_pins)
  );
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // An idle edge before each request keeps every strobe assigned once a step
  task automatic wr(input logic [7:0] a, d);
    tick(1);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    tick(1);
    req = '0;
  endtask
  task automatic bwr(input logic [7:0] a, input logic [2:0] b, input logic v);
    tick(1);
    req.bit_wr = 1'b1;
    req.addr = a;
    req.bit_sel = b;
    req.wdata = {7'h00, v};
    tick(1);
    req = '0;
  endtask
  // Read data and its valid pulse are looked at in the cycle after the ask
  task automatic rdc(input string nm, input logic [7:0] a, input logic m,
                     input logic [7:0] exp);
    tick(1);
    req.rd = 1'b1;
    req.rmw = m;
    req.addr = a;
    tick(1);
    req = '0;
    chk("rvalid", {7'h00, rvalid}, 8'h01);
    chk(nm, rdata, exp);
  endtask
  task automatic t_reset();
    rdc("data", `PIO_ADR_PORT0_DATA, 1'b1, `PIO_RST_DATA);
    rdc("drv", `PIO_ADR_PORT0_DRVMODE, 1'b0, `PIO_RST_DRVMODE);
    rdc("cmp", `PIO_ADR_PORT1_CMPSEL, 1'b0, `PIO_RST_CMPSEL);
    rdc("exp", `PIO_ADR_PORT1_EXPLVL, 1'b0, `PIO_RST_EXPLVL);
    rdc("byp", `PIO_ADR_PORT0_BYPASS, 1'b0, `PIO_RST_BYPASS);
    rdc("ana", `PIO_ADR_PORT0_ANASEL, 1'b0, `PIO_RST_ANASEL);
    rdc("unmapped", 8'h81, 1'b0, 8'h00);
  endtask
  task automatic t_cfg();
    wr(`PIO_ADR_PORT0_BYPASS, 8'hC3);
    bwr(`PIO_ADR_PORT0_BYPASS, 3'd4, 1'b1);
    rdc("byp rb", `PIO_ADR_PORT0_BYPASS, 1'b0, 8'hD3);
    chk("byp out", byp, 8'hD3);
    wr(`PIO_ADR_PORT0_ANASEL, 8'h0F);
    chk("rx", rx, 8'h0F);
    chk("pu", pu, 8'h0F);
    wpd = 1'b1;
    tick(1);
    chk("pu off", pu, 8'h00);
    wpd = 1'b0;
    chk("p27", {7'h00, p27}, 8'h01);
  endtask
  task automatic t_pads();
    xbe = 1'b1;
    wr(`PIO_ADR_PORT0_DATA, 8'h5A);
    tick(3);
    chk("od oe", p0_oe, 8'hA5);
    chk("od out", p0_out, 8'h00);
    chk("hd low", hd, 8'h00);
    wr(`PIO_ADR_PORT0_DRVMODE, 8'hFF);
    tick(3);
    chk("pp oe", p0_oe, 8'hFF);
    chk("pp out", p0_out, 8'h5A);
    // Pin0 handed to a peripheral driving high while its latch is low
    xsel = 8'h01;
    xdat = 8'h01;
    twi = 8'h02;
    drv = 8'hFF;
    tick(4);
    chk("twi oe", p0_oe, 8'hFD);
    chk("hd", hd, 8'hFD);
    rdc("pins", `PIO_ADR_PORT0_DATA, 1'b0, 8'h5B);
    rdc("latch", `PIO_ADR_PORT0_DATA, 1'b1, 8'h5A);
    bwr(`PIO_ADR_PORT0_DATA, 3'd7, 1'b1);
    rdc("latch b7", `PIO_ADR_PORT0_DATA, 1'b1, 8'hDA);
    wr(`PIO_ADR_PORT0_ANASEL, 8'h00);
    tick(2);
    chk("ana oe", p0_oe, 8'hFD);
    xbe = 1'b0;
    tick(2);
    chk("xbar off", p0_oe, 8'h00);
  endtask
  task automatic t_match();
    p1_lvl = 8'hFE;
    tick(4);
    chk("masked", {7'h00, mism}, 8'h00);
    wr(`PIO_ADR_PORT1_CMPSEL, 8'h01);
    tick(3);
    chk("mism hi", {7'h00, mism}, 8'h01);
    wr(`PIO_ADR_PORT1_EXPLVL, 8'hFE);
    tick(3);
    chk("mism lo", {7'h00, mism}, 8'h00);
    p1_lvl = 8'hFF;
    tick(2);
    chk("sync lag", {7'h00, mism}, 8'h00);
    tick(1);
    chk("mism held", {7'h00, mism}, 8'h01);
    wr(`PIO_ADR_PORT1_CMPSEL, 8'h00);
    cmp0 = 8'h80;
    exp0 = 8'h00;
    tick(4);
    chk("port0 mism", {7'h00, mism}, 8'h01);
    exp0 = 8'h80;
    tick(4);
    chk("port0 ok", {7'h00, mism}, 8'h00);
  endtask
  task automatic t_ce();
    ce = 1'b0;
    wr(`PIO_ADR_PORT0_BYPASS, 8'h00);
    chk("ce hold", byp, 8'hD3);
    ce = 1'b1;
    rdc("ce rb", `PIO_ADR_PORT0_BYPASS, 1'b0, 8'hD3);
  endtask
  // Write then read the same register on consecutive edges
  task automatic t_b2b();
    tick(1);
    req.wr = 1'b1;
    req.addr = `PIO_ADR_PORT0_ANASEL;
    req.wdata = 8'hA5;
    tick(1);
    req.wr = 1'b0;
    req.rd = 1'b1;
    tick(1);
    req = '0;
    chk("b2b rb", rdata, 8'hA5);
  endtask
  task automatic t_rst2();
    rstn = 1'b0;
    tick(2);
    chk("rst oe", p0_oe, 8'h00);
    chk("rst rdata", rdata, 8'h00);
    rstn = 1'b1;
    rdc("rst data", `PIO_ADR_PORT0_DATA, 1'b1, `PIO_RST_DATA);
    rdc("rst ana", `PIO_ADR_PORT0_ANASEL, 1'b0, `PIO_RST_ANASEL);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    tick(1);
    t_reset();
    t_cfg();
    t_ce();
    t_pads();
    t_match();
    t_b2b();
    t_rst2();
    results();
  end
  // The tests need about 108 cycles; this span of 5000 cycles is far beyond that
  initial begin
    #20000;
    errors++;
    results();
  end
endmodule
`default_nettype wire
